/* pia_pkg.sv */
// package: register map, fields and types of the phy indirect access engine
package pia_pkg;
  localparam logic [11:0] PIA_DATA_OFFSET = 12'h0a4;
  localparam logic [11:0] PIA_CMD_OFFSET = 12'h0a8;
  localparam int PIA_ADDR_MSB = 15;
  localparam int PIA_ADDR_LSB = 11;
  localparam int PIA_INDEX_MSB = 10;
  localparam int PIA_INDEX_LSB = 6;
  localparam int PIA_WNR_BIT = 1;
  localparam int PIA_BUSY_BIT = 0;
  localparam logic [4:0] PIA_ADDR_RESET = 5'h00;
  localparam logic [4:0] PIA_INDEX_RESET = 5'h00;
  localparam logic [15:0] PIA_DATA_RESET = 16'h0000;
  // mdc = aclk / (2 * half period), 2.5 MHz max
  localparam int PIA_MDC_HALF_NS = 200;
  localparam int PIA_CLK_NS = 10;
  localparam int PIA_MDC_HALF_CYC = (PIA_MDC_HALF_NS + PIA_CLK_NS - 1) / PIA_CLK_NS;
  localparam int PIA_FRAME_BITS = 64;
  localparam logic [1:0] PIA_RESP_OKAY = 2'b00;
  localparam logic [1:0] PIA_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] target_reg_index;
    logic write_not_read;
  } pia_cmd_t;

  typedef struct packed {
    logic mdc;
    logic mdio_o;
    logic mdio_oe;
  } pia_mdio_t;
endpackage : pia_pkg

/* pia_phy_access.sv */
// phy indirect access engine: axi4-lite registers driving a clause 22 frame
`timescale 1ns/10ps
module pia_phy_access
  import pia_pkg::*;
#(
  parameter logic [4:0] VPHY_ADDR = 5'h00
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pia_mdio_t mdio_out,
  input wire logic mdio_i
);

  typedef enum logic [1:0] {PIA_IDLE, PIA_SHIFT, PIA_DONE} pia_state_t;

  pia_state_t state_reg;
  pia_cmd_t cmd_reg;
  logic [15:0] wr_data_reg;
  logic [15:0] rd_data_reg;
  logic busy_reg;
  logic [63:0] shift_reg;
  logic [6:0] bit_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic mdc_reg;
  logic mdio_o_reg;
  logic mdio_oe_reg;
  logic [2:0] mdio_sync_reg;
  logic mdio_in_reg;
  logic [11:0] awaddr_reg;
  logic awready_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic arready_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  function automatic logic pia_hit(input logic [11:0] a, input logic [11:0] off);
    pia_hit = (a[11:2] == off[11:2]);
  endfunction : pia_hit

  wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_cmd = do_write && pia_hit(awaddr_reg, PIA_CMD_OFFSET);
  wire wr_data = do_write && pia_hit(awaddr_reg, PIA_DATA_OFFSET);
  wire wr_ok = wr_cmd || wr_data;
  wire do_read = s_axi_arvalid && !rvalid_reg;
  wire rd_cmd = pia_hit(s_axi_araddr, PIA_CMD_OFFSET);
  wire rd_data = pia_hit(s_axi_araddr, PIA_DATA_OFFSET);
  // a command landing mid-frame is dropped; software must poll busy first
  wire launch = wr_cmd && !busy_reg && wstrb_reg[1] && wstrb_reg[0];
  // the virtual phy answers on its strap address; never let frames reach it
  wire vphy_hit = (wdata_reg[PIA_ADDR_MSB:PIA_ADDR_LSB] == VPHY_ADDR);
  wire [31:0] cmd_word = {16'h0000, cmd_reg.phy_addr, cmd_reg.target_reg_index,
                          4'h0, cmd_reg.write_not_read, busy_reg};
  wire [15:0] data_view = cmd_reg.write_not_read ? wr_data_reg : rd_data_reg;
  wire [31:0] rd_word = rd_cmd ? cmd_word : (rd_data ? {16'h0000, data_view} : 32'h0000_0000);
  wire mdc_tick = (div_cnt_reg == 8'(PIA_MDC_HALF_CYC - 1));
  wire fall_edge = mdc_tick && mdc_reg;
  wire rise_edge = mdc_tick && !mdc_reg;
  wire last_bit = (bit_cnt_reg == 7'(PIA_FRAME_BITS - 1));
  // preamble, start 01, op, phy, reg, turnaround, data
  wire [63:0] frame = {32'hffff_ffff, 2'b01,
                       cmd_reg.write_not_read ? 2'b01 : 2'b10,
                       cmd_reg.phy_addr, cmd_reg.target_reg_index,
                       cmd_reg.write_not_read ? 2'b10 : 2'b11,
                       cmd_reg.write_not_read ? wr_data_reg : 16'hffff};
  // read frames release the line from turnaround onward
  wire drive_bit = cmd_reg.write_not_read || (bit_cnt_reg < 7'd46);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_reg <= 12'h000;
      awready_reg <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= PIA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (do_write)
      begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? PIA_RESP_OKAY : PIA_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= PIA_RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid_reg <= 1'b1;
      arready_reg <= 1'b0;
      rdata_reg <= rd_word;
      rresp_reg <= (rd_cmd || rd_data) ? PIA_RESP_OKAY : PIA_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_reg <= '{PIA_ADDR_RESET, PIA_INDEX_RESET, 1'b0};
      wr_data_reg <= PIA_DATA_RESET;
    end
    else
    begin
      if (launch)
      begin
        cmd_reg.phy_addr <= wdata_reg[PIA_ADDR_MSB:PIA_ADDR_LSB];
        cmd_reg.target_reg_index <= wdata_reg[PIA_INDEX_MSB:PIA_INDEX_LSB];
        cmd_reg.write_not_read <= wdata_reg[PIA_WNR_BIT];
      end
      if (wr_data && !busy_reg)
      begin
        if (wstrb_reg[0])
          wr_data_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          wr_data_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mdio_sync_reg <= 3'b111;
    else
      mdio_sync_reg <= {mdio_sync_reg[1:0], mdio_i};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mdio_in_reg <= 1'b1;
    else if (mdio_sync_reg[1] == mdio_sync_reg[2])
      mdio_in_reg <= mdio_sync_reg[2];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= PIA_IDLE;
      busy_reg <= 1'b0;
      shift_reg <= 64'h0;
      bit_cnt_reg <= 7'd0;
      div_cnt_reg <= 8'd0;
      mdc_reg <= 1'b0;
      mdio_o_reg <= 1'b1;
      mdio_oe_reg <= 1'b0;
      rd_data_reg <= PIA_DATA_RESET;
    end
    else
    begin
      case (state_reg)
        PIA_IDLE:
        begin
          mdc_reg <= 1'b0;
          div_cnt_reg <= 8'd0;
          bit_cnt_reg <= 7'd0;
          if (launch)
          begin
            busy_reg <= 1'b1;
            // virtual phy target: busy still pulses, no frame goes out
            state_reg <= vphy_hit ? PIA_DONE : PIA_SHIFT;
          end
        end
        PIA_SHIFT:
        begin
          div_cnt_reg <= mdc_tick ? 8'd0 : div_cnt_reg + 8'd1;
          if (mdc_tick)
            mdc_reg <= !mdc_reg;
          if (div_cnt_reg == 8'd0 && !mdc_reg && bit_cnt_reg == 7'd0 && !mdio_oe_reg)
            shift_reg <= frame;
          if (fall_edge || (div_cnt_reg == 8'd0 && !mdc_reg && !mdio_oe_reg))
          begin
            mdio_oe_reg <= drive_bit;
            mdio_o_reg <= (bit_cnt_reg == 7'd0) ? frame[63] : shift_reg[63];
          end
          if (rise_edge)
          begin
            shift_reg <= {shift_reg[62:0], mdio_in_reg};
            if (bit_cnt_reg >= 7'd48 && !cmd_reg.write_not_read)
              rd_data_reg <= {rd_data_reg[14:0], mdio_in_reg};
            bit_cnt_reg <= bit_cnt_reg + 7'd1;
            if (last_bit)
              state_reg <= PIA_DONE;
          end
        end
        PIA_DONE:
        begin
          mdio_oe_reg <= 1'b0;
          mdc_reg <= 1'b0;
          busy_reg <= 1'b0;
          state_reg <= PIA_IDLE;
        end
        default:
          state_reg <= PIA_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign mdio_out = '{mdc_reg, mdio_o_reg, mdio_oe_reg};

  sequence s_launch;
    launch && !vphy_hit;
  endsequence

  a_busy_on_launch: assert property (@(posedge aclk) disable iff (!aresetn)
    launch |=> busy_reg) else $error("busy not set after command write");
  a_busy_held: assert property (@(posedge aclk) disable iff (!aresetn)
    s_launch |=> busy_reg [*8]) else $error("busy dropped early");
  a_busy_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == PIA_DONE) |=> !busy_reg) else $error("busy did not self clear");
  a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == PIA_IDLE && !$past(launch)) |-> !mdio_oe_reg) else $error("mdio driven idle");
  a_vphy_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (launch && vphy_hit) |=> ##1 !busy_reg && !mdio_oe_reg) else $error("virtual phy reached");
  a_read_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(busy_reg) |-> $stable(rd_data_reg)) else $error("data moved");
  a_addr_latched: assert property (@(posedge aclk) disable iff (!aresetn)
    launch |=> cmd_reg.phy_addr == $past(wdata_reg[15:11])) else $error("address not latched");
  a_wr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && busy_reg) |=> $stable(wr_data_reg)) else $error("data written while busy");
endmodule : pia_phy_access

/* pia_phy_model.sv */
// behavioural internal phy answering clause 22 management frames
`timescale 1ns/10ps
module pia_phy_model
(
  input wire logic mdc,
  input wire logic mdio,
  output logic drv_oe,
  output logic drv_o,
  output logic [63:0] frame,
  output int nfrm
);
  initial
  begin
    drv_oe = 1'h0;
    drv_o = 1'h1;
    nfrm = 0;
  end
  int cnt = 0;
  logic [63:0] sh;
  logic [1:0] op = 2'h0;
  logic [15:0] val;
  always @(posedge mdc)
  begin
    sh = {sh[62:0], mdio};
    cnt = cnt + 1;
    if (cnt == 36)
      op = sh[1:0];
    if (cnt == 46)
      val = {sh[9:0], 6'h2a};
    if (cnt == 64)
    begin
      frame = sh;
      nfrm = nfrm + 1;
      cnt = 0;
    end
  end
  // owns the line from the second turnaround bit; released line floats up
  always @(negedge mdc)
  begin
    drv_oe <= (op == 2'h2) && (cnt >= 47);
    drv_o <= (cnt == 47) ? 1'h0 : val[63 - cnt];
  end
endmodule : pia_phy_model

/* pia_phy_access_tb_top.sv */
// self-checking bench for the phy indirect access engine
`timescale 1ns/10ps
module pia_phy_access_tb_top
  import pia_pkg::*;
;
  localparam logic [4:0] VPHY = 5'h1e;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, drv_oe, drv_o, mdio_i;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [63:0] frame;
  pia_mdio_t mdio_out;
  int nfrm;
  int n_mismatch = 0;
  int check_count = 0;
  always #5 aclk = ~aclk;
  assign mdio_i = mdio_out.mdio_oe ? mdio_out.mdio_o : (drv_oe ? drv_o : 1'h1);
  pia_phy_access #(.VPHY_ADDR(VPHY)) i_pia_phy_access (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mdio_out(mdio_out), .mdio_i(mdio_i));
  pia_phy_model i_pia_phy_model (.mdc(mdio_out.mdc), .mdio(mdio_i), .drv_oe(drv_oe),
    .drv_o(drv_o), .frame(frame), .nfrm(nfrm));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    n_mismatch++;
    $display("unexpected %s: no answer", nm);
    report_and_stop();
  endtask : hang

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid)
        break;
    end
    bready <= 1'h0;
    if (n == 50)
      hang("bvalid");
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid)
        break;
    end
    rready <= 1'h0;
    if (n == 50)
      hang("rvalid");
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // polls the busy flag; a frame is some 2600 cycles
  task automatic wait_idle;
    logic [31:0] v;
    int n;
    for (n = 0; n < 2000; n++)
    begin
      rd(PIA_CMD_OFFSET, v, PIA_RESP_OKAY);
      if (v[PIA_BUSY_BIT] === 1'h0)
        break;
    end
    if (n == 2000)
      hang("busy clear");
  endtask : wait_idle

  function automatic logic [31:0] cmdw(logic [4:0] a, logic [4:0] i, logic w);
    return {16'h0000, a, i, 4'h0, w, 1'h0};
  endfunction : cmdw

  task automatic t_reset;
    logic [31:0] v;
    rd(PIA_CMD_OFFSET, v, PIA_RESP_OKAY);
    chk("cmd reset", 32'h0000_0000, v);
    rd(PIA_DATA_OFFSET, v, PIA_RESP_OKAY);
    chk("data reset", 32'h0000_0000, v);
  endtask : t_reset

  task automatic t_write;
    logic [31:0] v;
    int f0;
    f0 = nfrm;
    wait_idle();
    wr(PIA_DATA_OFFSET, 32'h0000_a5c3, PIA_RESP_OKAY);
    wr(PIA_CMD_OFFSET, cmdw(5'h03, 5'h11, 1'h1), PIA_RESP_OKAY);
    rd(PIA_CMD_OFFSET, v, PIA_RESP_OKAY);
    chk("busy set", cmdw(5'h03, 5'h11, 1'h1) | 32'h0000_0001, v);
    wait_idle();
    chk("frame count", f0 + 1, nfrm);
    chk("preamble", 32'hffff_ffff, frame[63:32]);
    chk("wr frame", {2'h1, 2'h1, 5'h03, 5'h11, 2'h2, 16'ha5c3}, frame[31:0]);
    rd(PIA_DATA_OFFSET, v, PIA_RESP_OKAY);
    chk("data wr", 32'h0000_a5c3, v);
  endtask : t_write

  task automatic t_read;
    logic [31:0] v;
    wr(PIA_CMD_OFFSET, cmdw(5'h1f, 5'h1f, 1'h0), PIA_RESP_OKAY);
    wait_idle();
    chk("rd frame", {2'h1, 2'h2, 5'h1f, 5'h1f, 2'h2, 16'hffea}, frame[31:0]);
    rd(PIA_DATA_OFFSET, v, PIA_RESP_OKAY);
    chk("data rd", 32'h0000_ffea, v);
  endtask : t_read

  task automatic t_vphy_unmapped;
    logic [31:0] v;
    int f0;
    f0 = nfrm;
    wr(PIA_CMD_OFFSET, cmdw(VPHY, 5'h01, 1'h0), PIA_RESP_OKAY);
    wait_idle();
    chk("vphy frames", f0, nfrm);
    wr(12'h0b0, 32'h0000_0001, PIA_RESP_SLVERR);
    rd(12'h0b0, v, PIA_RESP_SLVERR);
    chk("unmapped data", 32'h0000_0000, v);
  endtask : t_vphy_unmapped

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_write();
    t_read();
    t_vphy_unmapped();
    report_and_stop();
  end
endmodule : pia_phy_access_tb_top
